// ===== inc/abx_consts.svh
// Constants for the add and bit-clear execute unit
`ifndef ABX_CONSTS_SVH
`define ABX_CONSTS_SVH

`define ABX_APB_CTRL 12'h000
`define ABX_APB_INSTR 12'h004
`define ABX_APB_ACCUM 12'h008
`define ABX_APB_FLAGS 12'h00C
`define ABX_APB_FADDR 12'h010
`define ABX_APB_FDATA 12'h014
`define ABX_APB_COUNT 12'h018

`define ABX_FLAG_C 0
`define ABX_FLAG_DC 1
`define ABX_FLAG_Z 2

`define ABX_CTRL_EXEC 0
`define ABX_ACCUM_RST 8'h00
`define ABX_FLAGS_RST 3'h0
`define ABX_FILE_RST 8'h00
`define ABX_FILE_DEPTH 128

`endif

// ===== inc/abx_pkg.sv
// Types for the add and bit-clear execute unit
package abx_pkg;

   typedef logic [13:0] abx_instr_t;
   typedef logic [6:0] abx_faddr_t;

   typedef enum logic [2:0] {
      ABX_OP_NONE,
      ABX_OP_ADD_IMM,
      ABX_OP_AND_IMM,
      ABX_OP_ADD_REG,
      ABX_OP_AND_REG,
      ABX_OP_CLR_BIT
   } abx_op_e;

   typedef struct packed {
      abx_op_e op;
      logic [7:0] immediate_value;
      abx_faddr_t register_operand_addr;
      logic result_target_select;
      logic [2:0] position_index;
   } abx_dec_s;

   typedef struct packed {
      logic overflow_out_bit;
      logic half_byte_overflow_bit;
      logic null_result_bit;
   } abx_flags_s;

endpackage : abx_pkg

// ===== verilog/abx_decode.sv
// Instruction decoder for the add, mask and bit-clear group
module abx_decode
   import abx_pkg::*;
(
   // Instruction word
   input wire abx_pkg::abx_instr_t instr,
   // Decoded fields
   output abx_pkg::abx_dec_s dec
);
   import abx_pkg::*;

   always_comb begin
      dec.op = ABX_OP_NONE;
      dec.immediate_value = instr[7:0];
      dec.register_operand_addr = instr[6:0];
      dec.result_target_select = instr[7];
      dec.position_index = instr[9:7];
      unique casez (instr[13:8])
         6'b11111?: dec.op = ABX_OP_ADD_IMM;
         6'b111001: dec.op = ABX_OP_AND_IMM;
         6'b000111: dec.op = ABX_OP_ADD_REG;
         6'b000101: dec.op = ABX_OP_AND_REG;
         6'b0100??: dec.op = ABX_OP_CLR_BIT;
         default: dec.op = ABX_OP_NONE;
      endcase
   end

endmodule : abx_decode

// ===== verilog/abx_exec.sv
// Execute unit for add, mask and bit-clear instructions behind an APB slave
`include "abx_consts.svh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// - Add immediate to accumulator, result into accumulator.
// - Add-with-register takes address 0..127 and one-bit target select.
// - Mask accumulator with register; select 0 to accumulator, 1 to register.
// - Both adds update carry, half-byte carry and zero flags.
// - Both masks update only zero flag; carry flags unchanged.
// - Bit clear zeroes one register bit; other bits and flags kept.
// - Bit clear takes bit index 0..7 and address 0..127.
module abx_exec
   import abx_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Status seen by the core
   output abx_pkg::abx_flags_s FLAGS,
   output logic [7:0] ACCUM
);
   import abx_pkg::*;

   //////////////////////////////////////////////////////////////////////////
   // State
   logic [7:0] file_q [`ABX_FILE_DEPTH];
   logic [7:0] file_d [`ABX_FILE_DEPTH];
   logic [7:0] accum_q, accum_d;
   abx_flags_s flags_q, flags_d;
   abx_instr_t instr_q, instr_d;
   abx_faddr_t faddr_q, faddr_d;
   logic [31:0] prdata_q, prdata_d;
   logic [15:0] count_q, count_d;
   abx_dec_s dec;

   abx_decode u_decode (
      .instr(instr_q),
      .dec(dec)
   );

   //////////////////////////////////////////////////////////////////////////
   // Bus decode
   logic access;
   logic wr;
   logic rd_setup;
   logic mapped;
   logic wr_ctrl;
   logic wr_instr;
   logic wr_accum;
   logic wr_flags;
   logic wr_faddr;
   logic wr_fdata;
   logic [11:0] offs;
   assign access = PSEL & PENABLE;
   assign wr = access & PWRITE;
   // Read data is fetched in the setup cycle so that PRDATA leaves a flip-flop
   assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
   assign offs = {PADDR[11:2], 2'b00};
   assign PREADY = 1'b1;
   assign PSLVERR = access & ~mapped;

   // Mapped flag and one write strobe per register, except the read-only count
   always_comb begin
      mapped = 1'b0;
      wr_ctrl = 1'b0;
      wr_instr = 1'b0;
      wr_accum = 1'b0;
      wr_flags = 1'b0;
      wr_faddr = 1'b0;
      wr_fdata = 1'b0;
      unique case (offs)
         `ABX_APB_CTRL: begin
            mapped = 1'b1;
            wr_ctrl = wr;
         end
         `ABX_APB_INSTR: begin
            mapped = 1'b1;
            wr_instr = wr;
         end
         `ABX_APB_ACCUM: begin
            mapped = 1'b1;
            wr_accum = wr;
         end
         `ABX_APB_FLAGS: begin
            mapped = 1'b1;
            wr_flags = wr;
         end
         `ABX_APB_FADDR: begin
            mapped = 1'b1;
            wr_faddr = wr;
         end
         `ABX_APB_FDATA: begin
            mapped = 1'b1;
            wr_fdata = wr;
         end
         `ABX_APB_COUNT: begin
            mapped = 1'b1;
         end
         default: ;
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   // Datapath
   logic [7:0] operand;
   logic [7:0] freg;
   logic [7:0] and_res;
   logic [7:0] clr_res;
   logic [8:0] sum;
   logic [4:0] low_sum;
   logic exec;
   logic is_add;
   logic is_and;
   logic use_imm;

   // Unknown opcodes leave every register and the count alone
   assign exec = wr_ctrl && PWDATA[`ABX_CTRL_EXEC] && dec.op != ABX_OP_NONE;
   assign is_add = dec.op == ABX_OP_ADD_IMM || dec.op == ABX_OP_ADD_REG;
   assign is_and = dec.op == ABX_OP_AND_IMM || dec.op == ABX_OP_AND_REG;
   assign use_imm = dec.op == ABX_OP_ADD_IMM || dec.op == ABX_OP_AND_IMM;
   assign freg = file_q[dec.register_operand_addr];
   assign operand = use_imm ? dec.immediate_value : freg;
   assign sum = {1'b0, accum_q} + {1'b0, operand};
   assign low_sum = {1'b0, accum_q[3:0]} + {1'b0, operand[3:0]};
   assign and_res = accum_q & operand;

   always_comb begin
      clr_res = freg;
      clr_res[dec.position_index] = 1'b0;
   end

   //////////////////////////////////////////////////////////////////////////
   // Result routing
   logic [7:0] result;
   logic res_to_accum;
   logic res_to_file;

   always_comb begin
      result = 8'h00;
      res_to_accum = 1'b0;
      res_to_file = 1'b0;
      if (exec) begin
         unique case (dec.op)
            ABX_OP_ADD_IMM: begin
               result = sum[7:0];
               res_to_accum = 1'b1;
            end
            ABX_OP_AND_IMM: begin
               result = and_res;
               res_to_accum = 1'b1;
            end
            ABX_OP_ADD_REG: begin
               result = sum[7:0];
               res_to_accum = ~dec.result_target_select;
               res_to_file = dec.result_target_select;
            end
            ABX_OP_AND_REG: begin
               result = and_res;
               res_to_accum = ~dec.result_target_select;
               res_to_file = dec.result_target_select;
            end
            ABX_OP_CLR_BIT: begin
               result = clr_res;
               res_to_file = 1'b1;
            end
            default: ;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Instruction and file index registers
   always_comb begin
      instr_d = instr_q;
      faddr_d = faddr_q;
      if (wr_instr) begin
         instr_d = PWDATA[13:0];
      end
      if (wr_faddr) begin
         faddr_d = PWDATA[6:0];
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         instr_q <= 14'h0000;
         faddr_q <= 7'h00;
      end else begin
         instr_q <= instr_d;
         faddr_q <= faddr_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Accumulator and status flags
   always_comb begin
      accum_d = accum_q;
      flags_d = flags_q;
      if (wr_accum) begin
         accum_d = PWDATA[7:0];
      end
      if (wr_flags) begin
         flags_d.overflow_out_bit = PWDATA[`ABX_FLAG_C];
         flags_d.half_byte_overflow_bit = PWDATA[`ABX_FLAG_DC];
         flags_d.null_result_bit = PWDATA[`ABX_FLAG_Z];
      end
      if (res_to_accum) begin
         accum_d = result;
      end
      if (exec && is_add) begin
         flags_d.overflow_out_bit = sum[8];
         flags_d.half_byte_overflow_bit = low_sum[4];
         flags_d.null_result_bit = sum[7:0] == 8'h00;
      end
      // Masks touch the zero flag only; bit clear touches no flag
      if (exec && is_and) begin
         flags_d.null_result_bit = and_res == 8'h00;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         accum_q <= `ABX_ACCUM_RST;
         flags_q <= `ABX_FLAGS_RST;
      end else begin
         accum_q <= accum_d;
         flags_q <= flags_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // File registers, one generate step per entry
   for (genvar g = 0; g < `ABX_FILE_DEPTH; g++) begin : g_file
      always_comb begin
         file_d[g] = file_q[g];
         if (wr_fdata && faddr_q == 7'(g)) begin
            file_d[g] = PWDATA[7:0];
         end
         if (res_to_file && dec.register_operand_addr == 7'(g)) begin
            file_d[g] = result;
         end
      end

      always_ff @(posedge CLK) begin
         if (RST) begin
            file_q[g] <= `ABX_FILE_RST;
         end else begin
            file_q[g] <= file_d[g];
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Executed instruction count
   always_comb begin
      count_d = count_q;
      if (exec) begin
         count_d = count_q + 16'h0001;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         count_q <= 16'h0000;
      end else begin
         count_q <= count_d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Read data
   always_comb begin
      prdata_d = 32'h0000_0000;
      if (rd_setup) begin
         unique case (offs)
            `ABX_APB_INSTR: prdata_d[13:0] = instr_q;
            `ABX_APB_ACCUM: prdata_d[7:0] = accum_q;
            `ABX_APB_FLAGS: begin
               prdata_d[`ABX_FLAG_C] = flags_q.overflow_out_bit;
               prdata_d[`ABX_FLAG_DC] = flags_q.half_byte_overflow_bit;
               prdata_d[`ABX_FLAG_Z] = flags_q.null_result_bit;
            end
            `ABX_APB_FADDR: prdata_d[6:0] = faddr_q;
            `ABX_APB_FDATA: prdata_d[7:0] = file_q[faddr_q];
            `ABX_APB_COUNT: prdata_d[15:0] = count_q;
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         prdata_q <= 32'h0000_0000;
      end else begin
         prdata_q <= prdata_d;
      end
   end

   // Zero outside the access phase of a read, since it is cleared after every cycle that is not a read setup
   assign PRDATA = prdata_q;
   assign FLAGS = flags_q;
   assign ACCUM = accum_q;

endmodule : abx_exec

// ===== sim/abx_exec_monitor.sv
// Checker for the add and bit-clear execute unit
`include "abx_consts.svh"
module abx_exec_monitor
   import abx_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // APB
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // Status
   input wire abx_pkg::abx_flags_s FLAGS,
   input wire logic [7:0] ACCUM
);
   import abx_pkg::*;
   logic [13:0] instr_q;
   wire acc = PSEL && PENABLE;
   wire wr = acc && PWRITE;
   wire ex = wr && PADDR == `ABX_APB_CTRL && PWDATA[0];
   wire add_i = ex && instr_q[13:9] == 5'h1F;
   wire and_i = ex && instr_q[13:8] == 6'h39;
   wire [8:0] sum = {1'b0, ACCUM} + {1'b0, instr_q[7:0]};
   wire [4:0] half = {1'b0, ACCUM[3:0]} + {1'b0, instr_q[3:0]};
   always_ff @(posedge CLK) begin
      if (RST) instr_q <= 14'h0000;
      else if (wr && PADDR == `ABX_APB_INSTR) instr_q <= PWDATA[13:0];
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   a_bus_ready: assert property (acc |-> PREADY) else $error("no ready");
   a_idle_quiet: assert property (!acc |-> PRDATA == 32'h0 && !PSLVERR) else $error("idle out");
   a_state_hold: assert property (!wr |=> $stable(ACCUM) && $stable(FLAGS)) else $error("moved");
   a_add_sum: assert property (add_i |=> {FLAGS.overflow_out_bit, ACCUM} == $past(sum))
      else $error("add sum");
   a_add_flags: assert property (add_i |=> FLAGS.half_byte_overflow_bit == $past(half[4])
      && FLAGS.null_result_bit == (ACCUM == 8'h00)) else $error("add flags");
   a_and_imm: assert property (and_i |=> ACCUM == ($past(ACCUM) & $past(instr_q[7:0]))
      && FLAGS.null_result_bit == (ACCUM == 8'h00)) else $error("and imm");
   a_and_keep: assert property (ex && instr_q[13:8] inside {6'h39, 6'h05}
      |=> $stable(FLAGS[2:1])) else $error("and flags");
   a_clr_flags: assert property (ex && instr_q[13:10] == 4'h4 |=> $stable(FLAGS))
      else $error("clear flags");
   c_add: cover property (add_i);
   c_and: cover property (and_i);
   c_err: cover property (acc && PSLVERR);
endmodule : abx_exec_monitor

bind abx_exec abx_exec_monitor u_mon (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
   .PWDATA, .PRDATA, .PREADY, .PSLVERR, .FLAGS, .ACCUM);

// ===== sim/abx_exec_test.sv
// Self-checking bench for the add and bit-clear execute unit
`include "abx_consts.svh"
module abx_exec_test;
   timeunit 1ns;
   timeprecision 1ns;
   import abx_pkg::*;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0;
   logic [31:0] PRDATA, rd;
   logic PREADY, PSLVERR, err;
   abx_flags_s FLAGS;
   logic [7:0] ACCUM;
   int errors = 0;
   int tests_run = 0;
   int n_exec = 0;
   always #25 CLK = ~CLK;
   abx_exec DUT (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
      .PSLVERR, .FLAGS, .ACCUM);
   task automatic stop_test;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      bit done;
      done = 1'b0;
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      // Answer is taken at the rising edge that ends the access, before it updates anything
      for (int n = 0; n < 8 && !done; n++) begin
         @(posedge CLK);
         done = PREADY === 1'b1;
         rd = PRDATA;
         err = PSLVERR;
      end
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
      if (!done) begin
         errors++;
         stop_test();
      end
   endtask : apb
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rdc
   task automatic exec(input logic [13:0] i);
      apb(1'b1, `ABX_APB_INSTR, {18'h0, i});
      apb(1'b1, `ABX_APB_CTRL, 32'h1);
      n_exec++;
   endtask : exec
   task automatic setw(input logic [7:0] a, input logic [2:0] f);
      apb(1'b1, `ABX_APB_ACCUM, {24'h0, a});
      apb(1'b1, `ABX_APB_FLAGS, {29'h0, f});
   endtask : setw
   task automatic setf(input logic [6:0] f, input logic [7:0] v);
      apb(1'b1, `ABX_APB_FADDR, {25'h0, f});
      apb(1'b1, `ABX_APB_FDATA, {24'h0, v});
   endtask : setf
   task automatic t_imm;
      setw(8'hF8, 3'h0);
      exec(14'h3F08);
      rdc(`ABX_APB_ACCUM, 32'h0);
      rdc(`ABX_APB_FLAGS, 32'h7);
      check({24'h0, ACCUM}, 32'h0);
      exec(14'h3E15);
      rdc(`ABX_APB_FLAGS, 32'h0);
      setw(8'hA3, 3'h3);
      exec(14'h395F);
      rdc(`ABX_APB_ACCUM, 32'h3);
      rdc(`ABX_APB_FLAGS, 32'h3);
      check({29'h0, FLAGS}, 32'h6);
      // Not an opcode of this unit: nothing moves and the count stays
      exec(14'h3A55);
      n_exec--;
      check({24'h0, ACCUM}, 32'h3);
      $display("immediate ops end");
   endtask : t_imm
   task automatic t_reg;
      setf(7'h7F, 8'hC2);
      setw(8'h17, 3'h0);
      exec(14'h05FF);
      rdc(`ABX_APB_FDATA, 32'h2);
      exec(14'h077F);
      rdc(`ABX_APB_ACCUM, 32'h19);
      exec(14'h07FF);
      rdc(`ABX_APB_FDATA, 32'h1B);
      setf(7'h00, 8'hE6);
      exec(14'h0500);
      rdc(`ABX_APB_ACCUM, 32'h0);
      rdc(`ABX_APB_FLAGS, 32'h4);
      $display("register ops end");
   endtask : t_reg
   task automatic t_clr;
      logic [7:0] v;
      v = 8'hFF;
      setf(7'h7F, 8'hFF);
      setw(8'h00, 3'h5);
      for (int b = 0; b < 8; b++) begin
         exec({4'h4, b[2:0], 7'h7F});
         v[b] = 1'b0;
         rdc(`ABX_APB_FDATA, {24'h0, v});
      end
      rdc(`ABX_APB_FLAGS, 32'h5);
      rdc(12'h01C, 32'h0);
      check({31'h0, err}, 32'h1);
      rdc(`ABX_APB_COUNT, 32'(n_exec));
      $display("bit clear and bus end");
   endtask : t_clr
   initial begin
      repeat (12) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      t_imm();
      t_reg();
      t_clr();
      stop_test();
   end
endmodule : abx_exec_test
